// ---- logic/tcsm_pkg.sv ----
// Constants and types for the timer clock select and Timer 0/1 block.
// Assumes a byte-wide register set reached through 32-bit APB words.
package tcsm_pkg;

   // Register indices; byte address is four times the index
   localparam logic [7:0] TCSM_IDX_CLK_CTRL = 8'h8e;
   localparam logic [7:0] TCSM_IDX_CLK_EXTRA = 8'hf4;
   localparam logic [7:0] TCSM_IDX_TMR_CTRL = 8'h88;
   localparam logic [7:0] TCSM_IDX_TMR_MODE = 8'h89;
   localparam logic [7:0] TCSM_IDX_ZERO_LO = 8'h8a;
   localparam logic [7:0] TCSM_IDX_ONE_LO = 8'h8b;
   localparam logic [7:0] TCSM_IDX_ZERO_HI = 8'h8c;
   localparam logic [7:0] TCSM_IDX_ONE_HI = 8'h8d;
   localparam logic [7:0] TCSM_IDX_IRQ_EN = 8'ha8;
   localparam logic [7:0] TCSM_IDX_IRQ_CFG = 8'he4;

   // First clock register fields
   localparam int unsigned TCSM_BIT_C_HI = 7;
   localparam int unsigned TCSM_BIT_C_LO = 6;
   localparam int unsigned TCSM_BIT_B_HI = 5;
   localparam int unsigned TCSM_BIT_B_LO = 4;
   localparam int unsigned TCSM_BIT_ONE_CLK = 3;
   localparam int unsigned TCSM_BIT_ZERO_CLK = 2;
   localparam int unsigned TCSM_BIT_PRESCALE = 0;

   // Second clock register fields
   localparam int unsigned TCSM_BIT_E_HI = 3;
   localparam int unsigned TCSM_BIT_E_LO = 2;
   localparam int unsigned TCSM_BIT_D_HI = 1;
   localparam int unsigned TCSM_BIT_D_LO = 0;
   localparam logic [7:0] TCSM_EXTRA_MASK = 8'h0f;

   // Timer control register fields
   localparam int unsigned TCSM_BIT_ONE_FLAG = 7;
   localparam int unsigned TCSM_BIT_ONE_RUN = 6;
   localparam int unsigned TCSM_BIT_ZERO_FLAG = 5;
   localparam int unsigned TCSM_BIT_ZERO_RUN = 4;

   // Interrupt enable and input polarity fields
   localparam int unsigned TCSM_BIT_ZERO_IRQ_EN = 1;
   localparam int unsigned TCSM_BIT_ONE_IRQ_EN = 3;
   localparam int unsigned TCSM_BIT_POL_A = 3;
   localparam int unsigned TCSM_BIT_POL_B = 7;

   // Mode register: timer 1 in the upper nibble, timer 0 in the lower
   localparam int unsigned TCSM_BIT_MODE_ONE = 4;
   localparam int unsigned TCSM_BIT_MODE_ZERO = 0;

   localparam logic [7:0] TCSM_RST_BYTE = 8'h00;
   localparam logic [31:0] TCSM_RST_WORD = 32'h0000_0000;

   // Prescaler division counts
   localparam int unsigned TCSM_DIV_4 = 32'h0000_0004;
   localparam int unsigned TCSM_DIV_12 = 32'h0000_000c;
   localparam int unsigned TCSM_DIV_48 = 32'h0000_0030;
   localparam int unsigned TCSM_DIV_EXT = 32'h0000_0008;

   typedef enum logic [1:0] {
      TCSM_MODE_13BIT = 2'b00,
      TCSM_MODE_16BIT = 2'b01,
      TCSM_MODE_RELOAD = 2'b10,
      TCSM_MODE_SPLIT = 2'b11
   } tcsm_mode_e;

   typedef enum logic [1:0] {
      TCSM_PRE_DIV12 = 2'b00,
      TCSM_PRE_DIV4 = 2'b01,
      TCSM_PRE_DIV48 = 2'b10,
      TCSM_PRE_EXT8 = 2'b11
   } tcsm_prescale_e;

   typedef struct packed {
      logic gate_en;
      logic event_count_sel;
      tcsm_mode_e mode;
   } tcsm_tmr_cfg_s;

endpackage

// ---- logic/tcsm_tick_divider.sv ----
// Divides a stream of step pulses into one tick every DIV steps.
// Assumes the step input is already in the system clock domain.
`timescale 1ns/1ps
`default_nettype none
module tcsm_tick_divider #(
   parameter int unsigned DIV = 4
) (
   input wire logic i_clk_sys,
   input wire logic i_rst_n,
   input wire logic i_step,
   output logic o_tick
);
   localparam int unsigned CW = $clog2(DIV);
   localparam logic [CW-1:0] LAST = CW'(DIV - 1);

   logic [CW-1:0] count;

   always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
      if (!i_rst_n) begin
         count <= '0;
      end else if (i_step) begin
         count <= (count == LAST) ? '0 : CW'(count + 1'b1);
      end
   end

   assign o_tick = i_step && (count == LAST);
endmodule
`default_nettype wire

// ---- logic/tcsm_timer_clock_select.sv ----
// Timer clock selection and Timer 0/1 counting behind an APB slave.
// Assumes one 20 MHz system clock; pins arrive asynchronously.
`timescale 1ns/1ps
`default_nettype none
module tcsm_timer_clock_select (
   input wire logic i_clk_sys,
   input wire logic i_rst_n,
   input wire logic i_psel,
   input wire logic i_penable,
   input wire logic i_pwrite,
   input wire logic [11:0] i_paddr,
   input wire logic [31:0] i_pwdata,
   input wire logic [3:0] i_pstrb,
   output logic [31:0] o_prdata,
   output logic o_pready,
   output logic o_pslverr,
   input wire logic i_ext_osc_clk,
   input wire logic [1:0] i_tmr_event_pin,
   input wire logic i_ext_irq_a_input,
   input wire logic i_ext_irq_b_input,
   input wire logic [1:0] i_tmr_vec_ack,
   input wire logic [3:0] i_tmr_ext_clk_sel,
   input wire logic [3:0] i_tmr_split_mode,
   output logic [1:0] o_tmr_irq_req,
   output logic [3:0] o_tmr_lo_tick,
   output logic [3:0] o_tmr_hi_tick
);

   // Register state
   logic [7:0] timer_clock_control;
   logic [3:0] clk_extra;
   logic [1:0] tmr_run;
   logic [1:0] tmr_flag;
   logic [1:0] tmr_irq_en;
   logic [1:0] irq_polarity;
   tcsm_pkg::tcsm_tmr_cfg_s [1:0] tmr_cfg;
   logic [1:0][7:0] tmr_lo;
   logic [1:0][7:0] tmr_hi;

   // Bus decode
   logic [7:0] idx;
   logic addr_ok;
   logic access;
   logic wr_en;
   logic hit;
   logic [7:0] rd_byte;
   logic [7:0] wbyte;

   // Synchronisers: {ext osc, event pins, gate b, gate a}
   logic [4:0] in_meta;
   logic [4:0] in_sync;
   logic [4:0] in_prev;
   logic [1:0] evt_fall;
   logic ext_rise;
   logic [1:0] gate_active;

   // Clock sources
   logic tick4;
   logic tick12;
   logic tick48;
   logic tick_ext8;
   logic prescale_tick;
   logic [1:0] clk_sel;
   logic [1:0] tmr_tick;
   logic [1:0] cnt_en;
   logic [1:0][7:0] next_lo;
   logic [1:0][7:0] next_hi;
   logic [1:0] wrap;
   logic [3:0] lo_sel;
   logic [3:0] hi_sel;
   logic [3:0] next_lo_tick;
   logic [3:0] next_hi_tick;

   // APB slave
   assign idx = i_paddr[9:2];
   assign addr_ok = (i_paddr[11:10] == 2'b00) && (i_paddr[1:0] == 2'b00);
   assign access = i_psel && i_penable && o_pready;
   assign wr_en = access && i_pwrite && i_pstrb[0] && hit;
   assign wbyte = i_pwdata[7:0];

   always_comb begin
      hit = addr_ok;
      rd_byte = tcsm_pkg::TCSM_RST_BYTE;
      unique case (idx)
         tcsm_pkg::TCSM_IDX_CLK_CTRL: begin
            rd_byte = timer_clock_control;
         end
         tcsm_pkg::TCSM_IDX_CLK_EXTRA: begin
            rd_byte = {4'h0, clk_extra};
         end
         tcsm_pkg::TCSM_IDX_TMR_CTRL: begin
            rd_byte = {tmr_flag[1], tmr_run[1], tmr_flag[0], tmr_run[0], 4'h0};
         end
         tcsm_pkg::TCSM_IDX_TMR_MODE: begin
            rd_byte = {tmr_cfg[1], tmr_cfg[0]};
         end
         tcsm_pkg::TCSM_IDX_ZERO_LO: begin
            rd_byte = tmr_lo[0];
         end
         tcsm_pkg::TCSM_IDX_ONE_LO: begin
            rd_byte = tmr_lo[1];
         end
         tcsm_pkg::TCSM_IDX_ZERO_HI: begin
            rd_byte = tmr_hi[0];
         end
         tcsm_pkg::TCSM_IDX_ONE_HI: begin
            rd_byte = tmr_hi[1];
         end
         tcsm_pkg::TCSM_IDX_IRQ_EN: begin
            rd_byte = {4'h0, tmr_irq_en[1], 1'b0, tmr_irq_en[0], 1'b0};
         end
         tcsm_pkg::TCSM_IDX_IRQ_CFG: begin
            rd_byte = {irq_polarity[1], 3'h0, irq_polarity[0], 3'h0};
         end
         default: begin
            hit = 1'b0;
         end
      endcase
   end

   // One wait state: pready rises in the second access cycle
   always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_pready <= 1'b0;
         o_pslverr <= 1'b0;
         o_prdata <= tcsm_pkg::TCSM_RST_WORD;
      end else begin
         o_pready <= i_psel && i_penable && !o_pready;
         o_pslverr <= i_psel && i_penable && !o_pready && !hit;
         if (i_psel && i_penable && !o_pready && !i_pwrite && hit) begin
            o_prdata <= {24'h00_0000, rd_byte};
         end else begin
            o_prdata <= tcsm_pkg::TCSM_RST_WORD;
         end
      end
   end

   // Configuration registers
   always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
      if (!i_rst_n) begin
         timer_clock_control <= tcsm_pkg::TCSM_RST_BYTE;
         clk_extra <= 4'h0;
      end else if (wr_en) begin
         if (idx == tcsm_pkg::TCSM_IDX_CLK_CTRL) begin
            timer_clock_control <= wbyte;
         end
         if (idx == tcsm_pkg::TCSM_IDX_CLK_EXTRA) begin
            clk_extra <= wbyte[3:0] & tcsm_pkg::TCSM_EXTRA_MASK[3:0];
         end
      end
   end

   always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
      if (!i_rst_n) begin
         tmr_run <= 2'b00;
         tmr_cfg <= '0;
         tmr_irq_en <= 2'b00;
         irq_polarity <= 2'b00;
      end else if (wr_en) begin
         unique case (idx)
            tcsm_pkg::TCSM_IDX_TMR_CTRL: begin
               // Run bits only gate counting; counts are untouched
               tmr_run[0] <= wbyte[tcsm_pkg::TCSM_BIT_ZERO_RUN];
               tmr_run[1] <= wbyte[tcsm_pkg::TCSM_BIT_ONE_RUN];
            end
            tcsm_pkg::TCSM_IDX_TMR_MODE: begin
               tmr_cfg[0] <= wbyte[tcsm_pkg::TCSM_BIT_MODE_ZERO +: 4];
               tmr_cfg[1] <= wbyte[tcsm_pkg::TCSM_BIT_MODE_ONE +: 4];
            end
            tcsm_pkg::TCSM_IDX_IRQ_EN: begin
               tmr_irq_en[0] <= wbyte[tcsm_pkg::TCSM_BIT_ZERO_IRQ_EN];
               tmr_irq_en[1] <= wbyte[tcsm_pkg::TCSM_BIT_ONE_IRQ_EN];
            end
            tcsm_pkg::TCSM_IDX_IRQ_CFG: begin
               irq_polarity[0] <= wbyte[tcsm_pkg::TCSM_BIT_POL_A];
               irq_polarity[1] <= wbyte[tcsm_pkg::TCSM_BIT_POL_B];
            end
            default: begin
            end
         endcase
      end
   end

   // Input synchronisers
   always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
      if (!i_rst_n) begin
         in_meta <= 5'h00;
         in_sync <= 5'h00;
         in_prev <= 5'h00;
      end else begin
         in_meta <= {i_ext_osc_clk, i_tmr_event_pin, i_ext_irq_b_input, i_ext_irq_a_input};
         in_sync <= in_meta;
         in_prev <= in_sync;
      end
   end

   // Each level must stand one cycle to be seen, so half rate is the ceiling
   assign evt_fall = in_prev[3:2] & ~in_sync[3:2];
   assign ext_rise = in_sync[4] & ~in_prev[4];
   assign gate_active[0] = irq_polarity[0] ? in_sync[0] : ~in_sync[0];
   assign gate_active[1] = irq_polarity[1] ? in_sync[1] : ~in_sync[1];

   // Prescaler
   tcsm_tick_divider #(.DIV(tcsm_pkg::TCSM_DIV_4)) u_div4 (.i_clk_sys(i_clk_sys),
      .i_rst_n(i_rst_n), .i_step(1'b1), .o_tick(tick4));
   tcsm_tick_divider #(.DIV(tcsm_pkg::TCSM_DIV_12)) u_div12 (.i_clk_sys(i_clk_sys),
      .i_rst_n(i_rst_n), .i_step(1'b1), .o_tick(tick12));
   tcsm_tick_divider #(.DIV(tcsm_pkg::TCSM_DIV_48)) u_div48 (.i_clk_sys(i_clk_sys),
      .i_rst_n(i_rst_n), .i_step(1'b1), .o_tick(tick48));
   tcsm_tick_divider #(.DIV(tcsm_pkg::TCSM_DIV_EXT)) u_div_ext (.i_clk_sys(i_clk_sys),
      .i_rst_n(i_rst_n), .i_step(ext_rise), .o_tick(tick_ext8));

   always_comb begin
      unique case (tcsm_pkg::tcsm_prescale_e'(timer_clock_control[tcsm_pkg::TCSM_BIT_PRESCALE +: 2]))
         tcsm_pkg::TCSM_PRE_DIV12: prescale_tick = tick12;
         tcsm_pkg::TCSM_PRE_DIV4: prescale_tick = tick4;
         tcsm_pkg::TCSM_PRE_DIV48: prescale_tick = tick48;
         tcsm_pkg::TCSM_PRE_EXT8: prescale_tick = tick_ext8;
      endcase
   end

   // Timer 0/1 counting
   assign clk_sel[0] = timer_clock_control[tcsm_pkg::TCSM_BIT_ZERO_CLK];
   assign clk_sel[1] = timer_clock_control[tcsm_pkg::TCSM_BIT_ONE_CLK];

   always_comb begin
      for (int t = 0; t < 2; t++) begin
         // Clock select bit is bypassed in event mode
         if (tmr_cfg[t].event_count_sel) begin
            tmr_tick[t] = evt_fall[t];
         end else begin
            tmr_tick[t] = clk_sel[t] ? 1'b1 : prescale_tick;
         end
         cnt_en[t] = tmr_tick[t] && tmr_run[t]
            && (!tmr_cfg[t].gate_en || gate_active[t]);
      end
   end

   always_comb begin
      for (int t = 0; t < 2; t++) begin
         next_lo[t] = tmr_lo[t];
         next_hi[t] = tmr_hi[t];
         wrap[t] = 1'b0;
         unique case (tmr_cfg[t].mode)
            tcsm_pkg::TCSM_MODE_13BIT: begin
               // Upper three low-byte bits are left as they are
               {next_hi[t], next_lo[t][4:0]} = {tmr_hi[t], tmr_lo[t][4:0]} + 13'h0001;
               wrap[t] = &{tmr_hi[t], tmr_lo[t][4:0]};
            end
            tcsm_pkg::TCSM_MODE_16BIT: begin
               {next_hi[t], next_lo[t]} = {tmr_hi[t], tmr_lo[t]} + 16'h0001;
               wrap[t] = &{tmr_hi[t], tmr_lo[t]};
            end
            tcsm_pkg::TCSM_MODE_RELOAD: begin
               next_lo[t] = (&tmr_lo[t]) ? tmr_hi[t] : 8'(tmr_lo[t] + 8'h01);
               wrap[t] = &tmr_lo[t];
            end
            tcsm_pkg::TCSM_MODE_SPLIT: begin
               // Split mode is not counted anywhere; both bytes hold
               wrap[t] = 1'b0;
            end
         endcase
      end
   end

   // Software byte writes win over a count in the same cycle
   always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
      if (!i_rst_n) begin
         tmr_lo <= '0;
         tmr_hi <= '0;
      end else begin
         for (int t = 0; t < 2; t++) begin
            if (wr_en && idx == (t == 0 ? tcsm_pkg::TCSM_IDX_ZERO_LO
                                        : tcsm_pkg::TCSM_IDX_ONE_LO)) begin
               tmr_lo[t] <= wbyte;
            end else if (cnt_en[t]) begin
               tmr_lo[t] <= next_lo[t];
            end
            if (wr_en && idx == (t == 0 ? tcsm_pkg::TCSM_IDX_ZERO_HI
                                        : tcsm_pkg::TCSM_IDX_ONE_HI)) begin
               tmr_hi[t] <= wbyte;
            end else if (cnt_en[t]) begin
               tmr_hi[t] <= next_hi[t];
            end
         end
      end
   end

   // Overflow flags: a wrap in the same cycle beats any clear
   always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
      if (!i_rst_n) begin
         tmr_flag <= 2'b00;
      end else begin
         for (int t = 0; t < 2; t++) begin
            if (cnt_en[t] && wrap[t]) begin
               tmr_flag[t] <= 1'b1;
            end else if (wr_en && idx == tcsm_pkg::TCSM_IDX_TMR_CTRL) begin
               tmr_flag[t] <= wbyte[t == 0 ? tcsm_pkg::TCSM_BIT_ZERO_FLAG
                                           : tcsm_pkg::TCSM_BIT_ONE_FLAG];
            end else if (i_tmr_vec_ack[t]) begin
               tmr_flag[t] <= 1'b0;
            end
         end
      end
   end

   always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_tmr_irq_req <= 2'b00;
      end else begin
         o_tmr_irq_req <= tmr_flag & tmr_irq_en;
      end
   end

   // Timers B..E clock ticks
   // Index 0..3 stands for timers B, C, D, E
   assign lo_sel = {clk_extra[tcsm_pkg::TCSM_BIT_E_LO],
                    clk_extra[tcsm_pkg::TCSM_BIT_D_LO],
                    timer_clock_control[tcsm_pkg::TCSM_BIT_C_LO],
                    timer_clock_control[tcsm_pkg::TCSM_BIT_B_LO]};
   assign hi_sel = {clk_extra[tcsm_pkg::TCSM_BIT_E_HI],
                    clk_extra[tcsm_pkg::TCSM_BIT_D_HI],
                    timer_clock_control[tcsm_pkg::TCSM_BIT_C_HI],
                    timer_clock_control[tcsm_pkg::TCSM_BIT_B_HI]};

   always_comb begin
      for (int k = 0; k < 4; k++) begin
         // Own source is the external clock over eight or the system clock over twelve
         next_lo_tick[k] = lo_sel[k] ? 1'b1 : (i_tmr_ext_clk_sel[k] ? tick_ext8 : tick12);
         next_hi_tick[k] = i_tmr_split_mode[k]
            && (hi_sel[k] ? 1'b1 : (i_tmr_ext_clk_sel[k] ? tick_ext8 : tick12));
      end
   end

   always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_tmr_lo_tick <= 4'h0;
         o_tmr_hi_tick <= 4'h0;
      end else begin
         o_tmr_lo_tick <= next_lo_tick;
         o_tmr_hi_tick <= next_hi_tick;
      end
   end

endmodule
`default_nettype wire

// ---- verif/tcsm_pin_model.sv ----
// Model of the pins outside the block: oscillator, event and gate inputs.
// Assumes tasks are called right after a system clock edge.
`timescale 1ns/1ps
`default_nettype none
module tcsm_pin_model #(
   parameter real OSC_HALF_NS = 85.3
) (
   input wire logic i_clk_sys,
   output logic o_ext_osc_clk,
   output logic [1:0] o_tmr_event_pin,
   output logic o_ext_irq_a_input,
   output logic o_ext_irq_b_input
);
   initial begin
      o_ext_osc_clk = 1'b0;
      o_tmr_event_pin = 2'b11;
      o_ext_irq_a_input = 1'b0;
      o_ext_irq_b_input = 1'b0;
   end
   // Free-running oscillator, phase unrelated to the system clock
   always #(OSC_HALF_NS) o_ext_osc_clk = ~o_ext_osc_clk;
   // Each level held two cycles: half the fastest legal event rate
   task automatic send_events(input int t, input int n);
      repeat (n) begin
         o_tmr_event_pin[t] <= 1'b0;
         repeat (2) @(posedge i_clk_sys);
         o_tmr_event_pin[t] <= 1'b1;
         repeat (2) @(posedge i_clk_sys);
      end
   endtask
   // Bit 1 drives the timer one gate pin, bit 0 the timer zero gate pin
   task automatic set_gate(input logic [1:0] v);
      {o_ext_irq_b_input, o_ext_irq_a_input} <= v;
      @(posedge i_clk_sys);
   endtask
endmodule
`default_nettype wire

// ---- verif/tcsm_timer_clock_select_asserts.sv ----
// Port-level checker for the timer clock select block.
// Assumes the APB master holds address and direction through the pready edge.
`timescale 1ns/1ps
`default_nettype none
module tcsm_checker (
   input wire logic i_clk_sys,
   input wire logic i_rst_n,
   input wire logic i_psel,
   input wire logic i_penable,
   input wire logic i_pwrite,
   input wire logic [11:0] i_paddr,
   input wire logic [31:0] i_pwdata,
   input wire logic [3:0] i_pstrb,
   input wire logic [31:0] o_prdata,
   input wire logic o_pready,
   input wire logic o_pslverr,
   input wire logic [1:0] i_tmr_vec_ack,
   input wire logic [3:0] i_tmr_split_mode,
   input wire logic [1:0] o_tmr_irq_req,
   input wire logic [3:0] o_tmr_lo_tick,
   input wire logic [3:0] o_tmr_hi_tick
);
   logic [7:0] ctl;
   logic [3:0] ext;
   logic [1:0] ien;
   logic [7:0] idx;
   logic wr_ok;
   logic [3:0] lo_sel;
   logic [3:0] hi_sel;
   assign idx = i_paddr[9:2];
   assign wr_ok = i_psel & i_penable & o_pready & i_pwrite & i_pstrb[0] & ~o_pslverr;
   assign lo_sel = {ext[2], ext[0], ctl[6], ctl[4]};
   assign hi_sel = {ext[3], ext[1], ctl[7], ctl[5]};
   // Shadow of software-owned selects and interrupt enables, taken at the write edge
   always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
      if (!i_rst_n) begin
         ctl <= 8'h00;
         ext <= 4'h0;
         ien <= 2'b00;
      end else if (wr_ok) begin
         if (idx == tcsm_pkg::TCSM_IDX_CLK_CTRL) ctl <= i_pwdata[7:0];
         if (idx == tcsm_pkg::TCSM_IDX_CLK_EXTRA) ext <= i_pwdata[3:0];
         if (idx == tcsm_pkg::TCSM_IDX_IRQ_EN) ien <= {i_pwdata[3], i_pwdata[1]};
      end
   end
   default clocking cb @(posedge i_clk_sys); endclocking
   default disable iff (!i_rst_n);
   sequence apb_setup_s;
      i_psel && !i_penable;
   endsequence
   sequence apb_read_s;
      o_pready && !i_pwrite && !o_pslverr;
   endsequence
   apb_wait_a: assert property (apb_setup_s |-> ##1 !o_pready ##1 o_pready)
      else $error("ready not two cycles after setup");
   ready_pulse_a: assert property (o_pready |=> !o_pready)
      else $error("ready longer than one cycle");
   ready_gate_a: assert property (o_pslverr || o_prdata != 32'h0000_0000 |-> o_pready)
      else $error("read data or error outside ready");
   ctrl_read_a: assert property (apb_read_s ##0 idx == tcsm_pkg::TCSM_IDX_CLK_CTRL
      |-> o_prdata == {24'h00_0000, ctl})
      else $error("clock control readback wrong");
   extra_read_a: assert property (apb_read_s ##0 idx == tcsm_pkg::TCSM_IDX_CLK_EXTRA
      |-> o_prdata == {28'h000_0000, ext})
      else $error("extra clock readback wrong");
   lo_sysclk_a: assert property ((lo_sel & $past(lo_sel) & ~o_tmr_lo_tick) == 4'h0)
      else $error("low tick missing on system clock");
   hi_split_a: assert property ((hi_sel & $past(hi_sel) & i_tmr_split_mode
      & $past(i_tmr_split_mode) & ~o_tmr_hi_tick) == 4'h0)
      else $error("high tick missing in split mode");
   hi_nosplit_a: assert property ((~i_tmr_split_mode & ~$past(i_tmr_split_mode)
      & o_tmr_hi_tick) == 4'h0)
      else $error("high tick outside split mode");
   irq_enable_a: assert property ((o_tmr_irq_req & ~$past(o_tmr_irq_req) & ~$past(ien))
      == 2'b00)
      else $error("interrupt request while disabled");
   vec_clear_a: assert property (i_tmr_vec_ack[0] |-> ##2 !o_tmr_irq_req[0])
      else $error("vector acknowledge kept request");
endmodule
bind tcsm_timer_clock_select tcsm_checker u_tcsm_checker (.i_clk_sys, .i_rst_n, .i_psel,
   .i_penable, .i_pwrite, .i_paddr, .i_pwdata, .i_pstrb, .o_prdata, .o_pready, .o_pslverr,
   .i_tmr_vec_ack, .i_tmr_split_mode, .o_tmr_irq_req, .o_tmr_lo_tick, .o_tmr_hi_tick);
`default_nettype wire

// ---- verif/test_tcsm_timer_clock_select.sv ----
// Self-checking bench for the timer clock select block over APB.
// Assumes the pin model drives oscillator, event and gate pins.
`timescale 1ns/1ps
`default_nettype none
module test_tcsm_timer_clock_select;
   typedef struct packed {
      logic [7:0] idx;
      logic [7:0] wd;
      logic s;
      logic [7:0] exp;
      logic er;
   } tcsm_row_s;
   localparam logic [7:0] CTL = tcsm_pkg::TCSM_IDX_CLK_CTRL;
   localparam logic [7:0] EXT = tcsm_pkg::TCSM_IDX_CLK_EXTRA;
   localparam real OSC_NS = 170.6;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0000_0000;
   logic [3:0] pstrb = 4'h0;
   logic [1:0] vack = 2'h0;
   logic [3:0] xsel = 4'h5;
   logic [3:0] split = 4'h0;
   logic [31:0] prdata, rd, cnt, cnt2;
   logic pready, pslverr, osc, ga, gb, er;
   logic [1:0] evp, irq;
   logic [3:0] lot, hit;
   int err_total = 0;
   int checks_done = 0;
   int pexp [5] = '{40, 121, 10, int'(484 * 50.0 / (8 * OSC_NS)), 484};
   tcsm_row_s rows [11] = '{
      '{8'h8e, 8'hff, 1'b1, 8'hff, 1'b0}, '{8'h8e, 8'h33, 1'b0, 8'hff, 1'b0},
      '{8'h8e, 8'h00, 1'b1, 8'h00, 1'b0}, '{8'hf4, 8'hff, 1'b1, 8'h0f, 1'b0},
      '{8'hf4, 8'ha5, 1'b1, 8'h05, 1'b0}, '{8'h89, 8'ha5, 1'b1, 8'ha5, 1'b0},
      '{8'h8a, 8'h5a, 1'b1, 8'h5a, 1'b0}, '{8'h8c, 8'h3c, 1'b1, 8'h3c, 1'b0},
      '{8'h8b, 8'h11, 1'b1, 8'h11, 1'b0}, '{8'h8d, 8'h22, 1'b1, 8'h22, 1'b0},
      '{8'h90, 8'h77, 1'b1, 8'h00, 1'b1}};
   always #25 clk = ~clk;
   tcsm_timer_clock_select u_tcsm_timer_clock_select (.i_clk_sys(clk), .i_rst_n(rst_n),
      .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr),
      .i_pwdata(pwdata), .i_pstrb(pstrb), .o_prdata(prdata), .o_pready(pready),
      .o_pslverr(pslverr), .i_ext_osc_clk(osc), .i_tmr_event_pin(evp),
      .i_ext_irq_a_input(ga), .i_ext_irq_b_input(gb), .i_tmr_vec_ack(vack),
      .i_tmr_ext_clk_sel(xsel), .i_tmr_split_mode(split), .o_tmr_irq_req(irq),
      .o_tmr_lo_tick(lot), .o_tmr_hi_tick(hit));
   tcsm_pin_model u_tcsm_pin_model (.i_clk_sys(clk), .o_ext_osc_clk(osc),
      .o_tmr_event_pin(evp), .o_ext_irq_a_input(ga), .o_ext_irq_b_input(gb));
   task automatic report_and_stop();
      $display("checks %0d errors %0d", checks_done, err_total);
      if (err_total == 0 && checks_done > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask
   task automatic hang();
      err_total++;
      $display("BAD %0t wait ran out", $time);
      report_and_stop();
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         err_total++;
         $display("BAD %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic rng(input logic [31:0] got, input int lo, input int hi);
      chk(32'((got >= lo && got <= hi) === 1'b1), 32'h0000_0001);
   endtask
   task automatic xfer(input logic [7:0] idx, input logic w, input logic [7:0] wd, input logic s);
      int n;
      n = 0;
      psel <= 1'b1;
      pwrite <= w;
      paddr <= {2'b00, idx, 2'b00};
      pwdata <= {24'h00_0000, wd};
      pstrb <= {3'b000, s};
      @(posedge clk);
      penable <= 1'b1;
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
      if (n >= 20) hang();
   endtask
   task automatic wr(input logic [7:0] idx, input logic [7:0] wd);
      xfer(idx, 1'b1, wd, 1'b1);
   endtask
   task automatic rdc(input logic [7:0] idx, input logic [7:0] exp);
      xfer(idx, 1'b0, 8'h00, 1'b1);
      chk(rd, {24'h00_0000, exp});
   endtask
   task automatic wait_irq(input int b);
      int n;
      n = 0;
      while (irq[b] !== 1'b1 && n < 20) begin
         @(posedge clk);
         n++;
      end
      if (n >= 20) hang();
   endtask
   initial begin
      repeat (10) @(posedge clk);
      rst_n <= 1'b1;
      rdc(CTL, 8'h00);
      rdc(EXT, 8'h00);
      for (int i = 0; i < 11; i++) begin
         xfer(rows[i].idx, 1'b1, rows[i].wd, rows[i].s);
         xfer(rows[i].idx, 1'b0, 8'h00, 1'b1);
         chk({er, rd[30:0]}, {rows[i].er, 23'h00_0000, rows[i].exp});
      end
      wr(CTL, 8'hf0);
      wr(EXT, 8'h0f);
      split <= 4'hf;
      repeat (3) @(posedge clk);
      chk({24'h00_0000, lot, hit}, 32'h0000_00ff);
      split <= 4'h0;
      repeat (3) @(posedge clk);
      chk({28'h000_0000, hit}, 32'h0000_0000);
      wr(CTL, 8'h00);
      wr(EXT, 8'h00);
      cnt = 32'h0000_0000;
      cnt2 = 32'h0000_0000;
      repeat (240) begin
         @(posedge clk);
         cnt = cnt + 32'(lot[1]);
         cnt2 = cnt2 + 32'(lot[0]);
      end
      rng(cnt, 19, 21);
      rng(cnt2, 7, 10);
      // Timer zero wraps from all ones; low bit 5 set must not widen the count
      wr(8'h89, 8'h00);
      wr(CTL, 8'h04);
      wr(8'ha8, 8'h02);
      wr(8'h8c, 8'hff);
      wr(8'h8a, 8'h3f);
      wr(8'h88, 8'h10);
      wait_irq(0);
      rdc(8'h88, 8'h30);
      rdc(8'h8c, 8'h00);
      vack <= 2'b01;
      @(posedge clk);
      vack <= 2'b00;
      repeat (3) @(posedge clk);
      chk(32'(irq), 32'h0000_0000);
      rdc(8'h88, 8'h10);
      // Gate held low stops the count, high lets it run
      wr(8'h88, 8'h00);
      wr(8'h89, 8'h08);
      wr(8'he4, 8'h08);
      wr(8'h8a, 8'h00);
      wr(8'h88, 8'h10);
      repeat (20) @(posedge clk);
      rdc(8'h8a, 8'h00);
      u_tcsm_pin_model.set_gate(2'b01);
      repeat (20) @(posedge clk);
      xfer(8'h8a, 1'b0, 8'h00, 1'b1);
      chk(32'(rd[4:0] != 5'h00), 32'h0000_0001);
      u_tcsm_pin_model.set_gate(2'b00);
      wr(8'h89, 8'h00);
      for (int p = 0; p < 5; p++) begin
         wr(8'h88, 8'h00);
         wr(8'h8a, 8'h00);
         wr(8'h8c, 8'h00);
         wr(CTL, (p < 4) ? 8'(p) : 8'h04);
         wr(8'h88, 8'h10);
         repeat (480) @(posedge clk);
         wr(8'h88, 8'h00);
         xfer(8'h8a, 1'b0, 8'h00, 1'b1);
         cnt = {27'h000_0000, rd[4:0]};
         xfer(8'h8c, 1'b0, 8'h00, 1'b1);
         cnt = cnt + {19'h0_0000, rd[7:0], 5'h00};
         rng(cnt, pexp[p] - 2, pexp[p] + 2);
      end
      // Timer one counts pin events; its system clock select is ignored
      wr(8'h89, 8'h40);
      wr(CTL, 8'h08);
      wr(8'ha8, 8'h08);
      wr(8'h8b, 8'h1b);
      wr(8'h8d, 8'hff);
      wr(8'h88, 8'h40);
      rdc(8'h8b, 8'h1b);
      u_tcsm_pin_model.send_events(1, 5);
      wait_irq(1);
      rdc(8'h88, 8'hc0);
      rdc(8'h8d, 8'h00);
      wr(8'h88, 8'h00);
      repeat (3) @(posedge clk);
      chk(32'(irq), 32'h0000_0000);
      // Timer one gate, active low: held while its pin is high
      wr(8'h89, 8'h80);
      wr(8'h8b, 8'h00);
      u_tcsm_pin_model.set_gate(2'b10);
      wr(8'h88, 8'h40);
      repeat (20) @(posedge clk);
      rdc(8'h8b, 8'h00);
      u_tcsm_pin_model.set_gate(2'b00);
      repeat (20) @(posedge clk);
      xfer(8'h8b, 1'b0, 8'h00, 1'b1);
      chk(32'(rd[4:0] != 5'h00), 32'h0000_0001);
      // Reset in mid-run returns registers and outputs to zero
      rst_n <= 1'b0;
      repeat (2) @(posedge clk);
      chk({28'h000_0000, irq, pready, pslverr}, 32'h0000_0000);
      rst_n <= 1'b1;
      rdc(CTL, 8'h00);
      rdc(8'h88, 8'h00);
      report_and_stop();
   end
endmodule
`default_nettype wire
